//--- design/adcid_top.v
// Converter control, result, identification, mode and constant registers.
`timescale 1ns/10ps

`include "adcid_regs.vh"

module adcid_top #(
  parameter       CONV_CYCLES = `ADCID_CONV_CYCLES,
  parameter [5:0] ID_VERSION  = 6'h2a, // Arbitrary value.
  parameter [5:0] ID_DEVICE   = 6'h15, // Arbitrary value.
  parameter [3:0] ID_SUPPLIER = 4'h9   // Arbitrary value.
) (
  input  wire        clk_i,
  input  wire        rst_b_i,
  // Register access port.
  input  wire [3:0]  reg_addr_i,
  input  wire [15:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [15:0] reg_rdata_o,
  // Test pin.
  input  wire        test_pin_i,
  // Converter core.
  input  wire [9:0]  conv_sample_i,
  output reg         conv_power_o,
  output reg         conv_sync_o,
  output reg         conv_busy_o,
  output reg  [2:0]  conv_input_sel_o,
  output reg         vref_connect_o,
  output reg         ext_ref_o,
  // Mode outputs.
  output reg         aud_test_o,
  output reg         tel_test_o,
  output reg  [3:0]  prod_test_o,
  output reg         test_active_o,
  output reg         dyn_vflag_o,
  output reg         aud_offcan_dis_o,
  output reg  [1:0]  special_o,
  // Converter completion status.
  output reg         conv_int_stat_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************

  reg  [15:0] ctrl_reg;
  reg  [15:0] ctrl_next;
  reg  [15:0] mode_reg;
  reg  [15:0] mode_next;
  reg         valid_reg;
  reg         valid_next;
  reg         int_stat_reg;
  reg         int_stat_next;
  reg         int_clr_bit_reg;
  reg  [15:0] rdata_next;

  wire        test_pin_sync;
  wire        wr_ctrl;
  wire        wr_mode;
  wire        wr_int;
  wire        start_edge;
  wire        conv_abort;
  wire        conv_busy;
  wire        conv_done;
  wire [9:0]  conv_data;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Address match used by every write decode.
  function wr_hit;
    input       wr;
    input [3:0] addr;
    input [3:0] target;
    begin
      wr_hit = wr && (addr == target);
    end
  endfunction

  // Replace only the masked bits of a register with new data.
  function [15:0] merge;
    input [15:0] old_val;
    input [15:0] new_val;
    input [15:0] mask;
    begin
      merge = (old_val & ~mask) | (new_val & mask);
    end
  endfunction

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************

  // The test pin is asynchronous, so it is synchronised before gating writes.
  adcid_sync #(
    .WIDTH   (1)
  ) u_test_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .async_i (test_pin_i),
    .sync_o  (test_pin_sync)
  );

  // ****************************************************************
  // Write decode
  // ****************************************************************

  // Reserved, result, id and constant addresses simply ignore writes.
  assign wr_ctrl = wr_hit(reg_wr_i, reg_addr_i, `ADCID_ADDR_CTRL);
  assign wr_mode = wr_hit(reg_wr_i, reg_addr_i, `ADCID_ADDR_MODE);
  assign wr_int  = wr_hit(reg_wr_i, reg_addr_i, `ADCID_ADDR_INT);

  // ****************************************************************
  // Converter control register
  // ****************************************************************

  // Unused control bits are masked so they always read zero.
  always @* begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = reg_wdata_i & `ADCID_CTRL_MASK;
    end
  end

  // Only a rising start bit counts; rewriting one while it is one starts nothing.
  assign start_edge = wr_ctrl
                    && reg_wdata_i[`ADCID_CTRL_START]
                    && !ctrl_reg[`ADCID_CTRL_START]
                    && reg_wdata_i[`ADCID_CTRL_ENA];

  // Dropping the enable mid-run cuts power, so the run is abandoned.
  assign conv_abort = !ctrl_next[`ADCID_CTRL_ENA];

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_reg <= `ADCID_RST_CTRL;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************

  adcid_conv #(
    .CYCLES   (CONV_CYCLES)
  ) u_conv (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .start_i  (start_edge),
    .abort_i  (conv_abort),
    .sample_i (conv_sample_i),
    .busy_o   (conv_busy),
    .done_o   (conv_done),
    .data_o   (conv_data)
  );

  // ****************************************************************
  // Result valid flag
  // ****************************************************************

  // A start the sequencer takes clears the flag at once; completion sets it.
  // A start refused while disabled or mid-run leaves the flag alone, so a
  // start in the last run cycle cannot hide the result that just finished.
  always @* begin
    valid_next = valid_reg;
    if (start_edge && !conv_busy) begin
      valid_next = 1'b0;
    end else if (conv_done) begin
      valid_next = 1'b1;
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= valid_next;
    end
  end

  // ****************************************************************
  // Completion interrupt status
  // ****************************************************************

  // The clear acts on a zero-to-one change of the written clear bit.
  // A completion in the same cycle wins, so no event is lost.
  always @* begin
    int_stat_next = int_stat_reg;
    if (wr_int && reg_wdata_i[`ADCID_INT_ADC] && !int_clr_bit_reg) begin
      int_stat_next = 1'b0;
    end
    if (conv_done) begin
      int_stat_next = 1'b1;
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_stat_reg    <= 1'b0;
      int_clr_bit_reg <= 1'b0;
    end else begin
      int_stat_reg <= int_stat_next;
      if (wr_int) begin
        int_clr_bit_reg <= reg_wdata_i[`ADCID_INT_ADC];
      end
    end
  end

  // ****************************************************************
  // Mode register
  // ****************************************************************

  // Test bits follow the test pin gate; the flag and reserved bits are free.
  always @* begin
    mode_next = mode_reg;
    if (wr_mode) begin
      mode_next = merge(mode_reg, reg_wdata_i, `ADCID_MODE_FREE_MSK);
      if (test_pin_sync) begin
        mode_next = merge(mode_next, reg_wdata_i, `ADCID_MODE_TEST_MSK);
      end
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_reg <= `ADCID_RST_MODE;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************

  // Unmapped addresses and the reserved slot read zero.
  always @* begin
    rdata_next = 16'h0000;
    case (reg_addr_i)
      `ADCID_ADDR_CTRL: begin
        rdata_next = ctrl_reg;
      end
      `ADCID_ADDR_RESULT: begin
        rdata_next[`ADCID_RES_VALID]                  = valid_reg;
        rdata_next[`ADCID_RES_HI:`ADCID_RES_LO]        = conv_data;
      end
      `ADCID_ADDR_ID: begin
        rdata_next = {ID_SUPPLIER, ID_DEVICE, ID_VERSION};
      end
      `ADCID_ADDR_MODE: begin
        rdata_next = mode_reg;
      end
      `ADCID_ADDR_INT: begin
        rdata_next[`ADCID_INT_ADC] = int_stat_reg;
      end
      `ADCID_ADDR_RSVD: begin
        rdata_next = 16'h0000;
      end
      `ADCID_ADDR_ONES: begin
        rdata_next = `ADCID_ALL_ONES;
      end
      default: begin
        rdata_next = 16'h0000;
      end
    endcase
  end

  // Read data is registered and held until the next read strobe.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_next;
    end
  end

  // ****************************************************************
  // Converter and mode outputs
  // ****************************************************************

  // All outputs except conv_busy_o are registered copies of the next state, so they move
  // in the same cycle as the registers they mirror; conv_busy_o copies the sequencer
  // busy register and moves one cycle after it.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conv_power_o     <= 1'b0;
      conv_sync_o      <= 1'b0;
      conv_busy_o      <= 1'b0;
      conv_input_sel_o <= 3'h0;
      vref_connect_o   <= 1'b0;
      ext_ref_o        <= 1'b0;
      aud_test_o       <= 1'b0;
      tel_test_o       <= 1'b0;
      prod_test_o      <= 4'h0;
      test_active_o    <= 1'b0;
      dyn_vflag_o      <= 1'b0;
      aud_offcan_dis_o <= 1'b0;
      special_o        <= 2'h0;
      conv_int_stat_o  <= 1'b0;
    end else begin
      conv_power_o     <= ctrl_next[`ADCID_CTRL_ENA];
      conv_sync_o      <= ctrl_next[`ADCID_CTRL_SYNC];
      conv_busy_o      <= conv_busy;
      conv_input_sel_o <= ctrl_next[`ADCID_CTRL_MUX_HI:`ADCID_CTRL_MUX_LO];
      vref_connect_o   <= ctrl_next[`ADCID_CTRL_VREF];
      ext_ref_o        <= ctrl_next[`ADCID_CTRL_EXTREF];
      aud_test_o       <= mode_next[`ADCID_MODE_AUDT];
      tel_test_o       <= mode_next[`ADCID_MODE_TELT];
      prod_test_o      <= mode_next[`ADCID_MODE_PROD_HI:`ADCID_MODE_PROD_LO];
      test_active_o    <= |(mode_next & `ADCID_MODE_TEST_MSK);
      dyn_vflag_o      <= mode_next[`ADCID_MODE_DYNV];
      aud_offcan_dis_o <= mode_next[`ADCID_MODE_OFFC];
      special_o        <= mode_next[15:14];
      conv_int_stat_o  <= int_stat_next;
    end
  end

endmodule

//--- design/adcid_regs.vh
// Address map, field positions, reset values and timing counts of the converter and id registers.
//
// Function
// - A zero-to-one change of the start bit, written with bit 15 set while idle, begins exactly one conversion.
// - The result-valid bit reads zero while a conversion runs.
// - The result-valid bit reads one once the result is stored.
// - Ten-bit result sits read-only in bits 14:5; result and valid reset zero.
// - Bits 4:2 pick the input: 0-3 touch plates, 4-7 auxiliary inputs.
// - The converter is powered only while control bit 15 is one.
// - Control bit 0 selects synchronised converter mode.
// - Control bit 1 connects the internal reference to the bypass pin.
// - Control bit 5 selects an external reference supplied on the bypass pin.
// - Identification register is read-only: version, device and supplier constants.
// - Mode bits 0, 1 and 5:2 enable audio, telecom and production tests.
// - Test bits of the mode register are written only while the test pin is high.
// - Any active test mode alters normal behaviour; keep tests off normally.
// - Mode bit 12 selects dynamic data-valid flags for audio and telecom.
// - Mode bit 13 disables audio input offset cancellation.
// - Mode bits 14 and 15 are plain read-write reserved bits.
// - Address fourteen is reserved with no fields.
// - Address fifteen always reads all ones.
// - Completion sets interrupt status bit 11; a zero-to-one clear write resets it.

`ifndef ADCID_REGS_VH
`define ADCID_REGS_VH

// Register addresses.
`define ADCID_ADDR_INT      4'h4
`define ADCID_ADDR_CTRL     4'ha
`define ADCID_ADDR_RESULT   4'hb
`define ADCID_ADDR_ID       4'hc
`define ADCID_ADDR_MODE     4'hd
`define ADCID_ADDR_RSVD     4'he
`define ADCID_ADDR_ONES     4'hf

// Control register fields.
`define ADCID_CTRL_SYNC     0
`define ADCID_CTRL_VREF     1
`define ADCID_CTRL_MUX_LO   2
`define ADCID_CTRL_MUX_HI   4
`define ADCID_CTRL_EXTREF   5
`define ADCID_CTRL_START    7
`define ADCID_CTRL_ENA      15
`define ADCID_CTRL_MASK     16'h80bf

// Result register fields.
`define ADCID_RES_LO        5
`define ADCID_RES_HI        14
`define ADCID_RES_VALID     15

// Mode register fields.
`define ADCID_MODE_AUDT     0
`define ADCID_MODE_TELT     1
`define ADCID_MODE_PROD_LO  2
`define ADCID_MODE_PROD_HI  5
`define ADCID_MODE_DYNV     12
`define ADCID_MODE_OFFC     13
`define ADCID_MODE_TEST_MSK 16'h003f
`define ADCID_MODE_FREE_MSK 16'hf000

// Interrupt status position of converter completion.
`define ADCID_INT_ADC       11

// Reset values and constant read values.
`define ADCID_RST_CTRL      16'h0000
`define ADCID_RST_MODE      16'h0000
`define ADCID_ALL_ONES      16'hffff

// Conversion length in clock cycles.
`define ADCID_CONV_CYCLES   16

`endif

//--- design/adcid_sync.v
// Two-stage synchroniser for levels arriving from pins.
`timescale 1ns/10ps

module adcid_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk_i,
  input  wire             rst_b_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // The first stage feeds only the second, so metastability has a full cycle to settle.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule

//--- design/adcid_conv.v
// Conversion sequencer: times one conversion and captures the result.
`timescale 1ns/10ps

`include "adcid_regs.vh"

module adcid_conv #(
  parameter CYCLES = `ADCID_CONV_CYCLES
) (
  input  wire       clk_i,
  input  wire       rst_b_i,
  input  wire       start_i,
  input  wire       abort_i,
  input  wire [9:0] sample_i,
  output reg        busy_o,
  output reg        done_o,
  output reg  [9:0] data_o
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;
  localparam integer LAST_INT = CYCLES - 1;
  localparam [15:0]  LAST     = LAST_INT[15:0];

  reg [1:0]  state_reg;
  reg [15:0] count_reg;

  // One-hot sequencer; an abort drops the run without touching the stored data.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_IDLE;
      count_reg <= 16'h0000;
      busy_o    <= 1'b0;
      done_o    <= 1'b0;
      data_o    <= 10'h000;
    end else begin
      done_o <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start_i && !abort_i) begin
            state_reg <= ST_RUN;
            count_reg <= 16'h0000;
            busy_o    <= 1'b1;
          end
        end
        ST_RUN: begin
          if (abort_i) begin
            state_reg <= ST_IDLE;
            busy_o    <= 1'b0;
          end else if (count_reg == LAST) begin
            state_reg <= ST_IDLE;
            busy_o    <= 1'b0;
            done_o    <= 1'b1;
            data_o    <= sample_i;
          end else begin
            count_reg <= count_reg + 16'h0001;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          busy_o    <= 1'b0;
        end
      endcase
    end
  end

endmodule

//--- tb/adcid_props.sv
// Port checker for the converter, id and mode register bank.
`timescale 1ns/10ps
module adcid_props #(
  parameter       CONV_CYCLES = 16,
  parameter [5:0] ID_VERSION  = 6'h00,
  parameter [5:0] ID_DEVICE   = 6'h00,
  parameter [3:0] ID_SUPPLIER = 4'h0
) (
  input wire        clk_i,
  input wire        rst_b_i,
  input wire [3:0]  reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [15:0] reg_rdata_o,
  input wire        test_pin_i,
  input wire        conv_power_o,
  input wire        conv_sync_o,
  input wire        conv_busy_o,
  input wire [2:0]  conv_input_sel_o,
  input wire        vref_connect_o,
  input wire        ext_ref_o,
  input wire        aud_test_o,
  input wire        tel_test_o,
  input wire [3:0]  prod_test_o,
  input wire        test_active_o,
  input wire        dyn_vflag_o,
  input wire        aud_offcan_dis_o,
  input wire [1:0]  special_o,
  input wire        conv_int_stat_o
);
  // ********************************
  // Checks
  // ********************************
  localparam int CC = CONV_CYCLES;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Bus steps shared by the checks below.
  sequence s_ctrl_wr;
    reg_wr_i && reg_addr_i == 4'ha;
  endsequence
  sequence s_rd(logic [3:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence

  AST_CTRL_FIELDS: assert property (s_ctrl_wr |=> {conv_input_sel_o, conv_sync_o,
    vref_connect_o, ext_ref_o} == {$past(reg_wdata_i[4:2]), $past(reg_wdata_i[0]),
    $past(reg_wdata_i[1]), $past(reg_wdata_i[5])}) else $error("control mirror wrong");
  AST_POWER: assert property (s_ctrl_wr |=> conv_power_o == $past(reg_wdata_i[15]))
    else $error("power mirror wrong");
  AST_START_CAUSE: assert property ($rose(conv_busy_o) |->
    $past(reg_wr_i && reg_addr_i == 4'ha && reg_wdata_i[7] && reg_wdata_i[15], 2))
    else $error("run without enabled start write");
  AST_RUN_LEN: assert property ($rose(conv_busy_o) |-> ##[CC:CC]
    ($fell(conv_busy_o) || !conv_power_o)) else $error("run length wrong");
  AST_VALID_LOW: assert property (s_rd(4'hb) && conv_busy_o && !conv_int_stat_o
    |=> !reg_rdata_o[15]) else $error("valid set during run");
  AST_ID: assert property (s_rd(4'hc) |=>
    reg_rdata_o == {ID_SUPPLIER, ID_DEVICE, ID_VERSION}) else $error("id word wrong");
  AST_RSVD_ZERO: assert property (s_rd(4'he) |=> reg_rdata_o == 16'h0000)
    else $error("reserved slot not zero");
  AST_ONES: assert property (s_rd(4'hf) |=> reg_rdata_o == 16'hffff)
    else $error("constant word not all ones");
  AST_TEST_GATE: assert property (reg_wr_i && reg_addr_i == 4'hd && !test_pin_i &&
    !$past(test_pin_i) && !$past(test_pin_i, 2) |=>
    $stable({prod_test_o, tel_test_o, aud_test_o})) else $error("test bits written");
  AST_MODE_FREE: assert property (reg_wr_i && reg_addr_i == 4'hd |=>
    {special_o, aud_offcan_dis_o, dyn_vflag_o} == $past(reg_wdata_i[15:12]))
    else $error("mode upper bits wrong");
  AST_TEST_ACT: assert property (test_active_o == |{prod_test_o, tel_test_o, aud_test_o})
    else $error("test active flag wrong");
endmodule

bind adcid_top adcid_props #(.CONV_CYCLES(CONV_CYCLES), .ID_VERSION(ID_VERSION),
  .ID_DEVICE(ID_DEVICE), .ID_SUPPLIER(ID_SUPPLIER)) i_adcid_props (.*);

//--- tb/adcid_core_model.sv
// Behavioural converter core that hands the sequencer a sample code.
`timescale 1ns/10ps
module adcid_core_model (
  input  wire       clk_i,
  input  wire       power_i,
  input  wire [2:0] sel_i,
  input  wire [9:0] level_i,
  output wire [9:0] sample_o
);
  // ********************************
  // Sample source
  // ********************************
  reg [9:0] junk_reg = 10'h155;
  // An unpowered core gives no code, so a toggling word stands in for stale data.
  always @(posedge clk_i) begin
    junk_reg <= ~junk_reg;
  end
  // The channel shapes the code, so a wrong selector shows in the stored result.
  assign sample_o = power_i ? (level_i ^ {7'h00, sel_i}) : junk_reg;
endmodule

//--- tb/adcid_top_tb.sv
// Self-checking bench for the converter, id and mode register bank.
`timescale 1ns/10ps
module adcid_top_tb;
  localparam        CC  = 4;
  localparam [15:0] IDW = {4'h5, 6'h22, 6'h11};
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        test_pin_i = 1'b0;
  logic [9:0]  level = 10'h000;
  wire  [9:0]  conv_sample_i;
  wire  [15:0] reg_rdata_o;
  wire  [2:0]  conv_input_sel_o;
  wire  [3:0]  prod_test_o;
  wire  [1:0]  special_o;
  wire         conv_power_o, conv_sync_o, conv_busy_o, vref_connect_o, ext_ref_o;
  wire         aud_test_o, tel_test_o, test_active_o, dyn_vflag_o, aud_offcan_dis_o;
  wire         conv_int_stat_o;
  logic [15:0] exp_q[$];
  logic        rd_dly = 1'b0;
  int          err_count = 0;
  int          num_checks = 0;
  logic [15:0] d;
  logic [9:0]  s;
  logic [9:0]  p = 10'h000;
  logic [3:0]  ro[4] = '{4'hb, 4'hc, 4'he, 4'hf};
  logic [15:0] roe[4] = '{16'h0000, IDW, 16'h0000, 16'hffff};

  always #50 clk_i = ~clk_i;

  adcid_top #(.CONV_CYCLES(CC), .ID_VERSION(6'h11), .ID_DEVICE(6'h22),
    .ID_SUPPLIER(4'h5)) i_adcid_top (.*);
  adcid_core_model i_adcid_core_model (.clk_i(clk_i), .power_i(conv_power_o),
    .sel_i(conv_input_sel_o), .level_i(level), .sample_o(conv_sample_i));

  // ********************************
  // Helpers
  // ********************************
  task automatic fail(input string m);
    err_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One access, then an idle edge so a strobe is never driven twice at one edge.
  task automatic op(input logic w, input logic r, input logic [3:0] a, input logic [15:0] v);
    reg_wr_i <= w;
    reg_rd_i <= r;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    op(1'b1, 1'b0, a, v);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    op(1'b0, 1'b1, a, 16'h0000);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (conv_busy_o !== 1'b0 && n < 50);
    if (conv_busy_o !== 1'b0) begin
      fail("conversion never ended");
      report_and_stop();
    end
    @(posedge clk_i);
  endtask
  // Busy is looked at mid-cycle, then the bench returns to a rising edge to drive again.
  task automatic idle_chk();
    @(negedge clk_i);
    chk({15'h0, conv_busy_o}, 16'h0000);
    @(posedge clk_i);
  endtask

  // Read data lands one edge after the strobe; compare it with the oldest note.
  always @(posedge clk_i) rd_dly <= reg_rd_i;
  always @(negedge clk_i) begin
    if (rd_dly) begin
      if (exp_q.size() == 0) fail("read data without a note");
      else chk(reg_rdata_o, exp_q.pop_front());
    end
  end

  // A hung run still ends in the verdict.
  initial begin
    repeat (20000) @(posedge clk_i);
    fail("run limit reached");
    report_and_stop();
  end

  // ********************************
  // Scenarios
  // ********************************
  initial begin
    void'($urandom(97));
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    rd(4'ha, 16'h0000);
    rd(4'hd, 16'h0000);
    rd(4'h3, 16'h0000);
    foreach (ro[i]) rd(ro[i], roe[i]);
    foreach (ro[i]) begin
      wr(ro[i], 16'h5a5a);
      rd(ro[i], roe[i]);
    end
    // Every selector code with random control bits; start stays clear.
    for (int i = 0; i < 8; i++) begin
      d = (16'($urandom()) & 16'hff63) | {11'h0, i[2:0], 2'b00};
      wr(4'ha, d);
      chk({13'h0, conv_input_sel_o}, {13'h0, i[2:0]});
      chk({12'h0, conv_power_o, ext_ref_o, vref_connect_o, conv_sync_o},
        {12'h0, d[15], d[5], d[1], d[0]});
      rd(4'ha, d & 16'h80bf);
    end
    // Two runs on channel five, each with a held start and a status clear.
    repeat (2) begin
      s = 10'($urandom());
      level <= s;
      wr(4'ha, 16'h8014);
      wr(4'ha, 16'h8094);
      rd(4'hb, {1'b0, p, 5'h00});
      wait_idle();
      p = s ^ 10'h005;
      rd(4'hb, {1'b1, p, 5'h00});
      rd(4'h4, 16'h0800);
      wr(4'ha, 16'h8094);
      idle_chk();
      wr(4'h4, 16'h0000);
      wr(4'h4, 16'h0800);
      rd(4'h4, 16'h0000);
    end
    // A start while disabled, then a run cut short by clearing the enable.
    wr(4'ha, 16'h0000);
    wr(4'ha, 16'h0080);
    idle_chk();
    rd(4'hb, {1'b1, p, 5'h00});
    level <= 10'h3ff;
    wr(4'ha, 16'h8014);
    wr(4'ha, 16'h8094);
    wr(4'ha, 16'h0000);
    wait_idle();
    rd(4'hb, {1'b0, p, 5'h00});
    // Test bits follow the synchronised test pin; upper mode bits never do.
    wr(4'hd, 16'hffff);
    rd(4'hd, 16'hf000);
    chk({12'h0, special_o, aud_offcan_dis_o, dyn_vflag_o}, 16'h000f);
    test_pin_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    d = (16'($urandom()) & 16'hf03f) | 16'h0001;
    wr(4'hd, d);
    rd(4'hd, d);
    chk({10'h0, prod_test_o, tel_test_o, aud_test_o}, {10'h0, d[5:0]});
    chk({15'h0, test_active_o}, 16'h0001);
    wr(4'hd, 16'h0000);
    rd(4'hd, 16'h0000);
    test_pin_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    wr(4'hd, 16'h003f);
    rd(4'hd, 16'h0000);
    repeat (2) @(posedge clk_i);
    report_and_stop();
  end
endmodule
